//--- verilog/acr_defs.vh
// register offsets, field positions, reset values and test pattern codes for the output config bank
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

`define ACR_ADDR_W 13
`define ACR_REG_INDEX2 13'h004
`define ACR_REG_INDEX1 13'h005
`define ACR_REG_CLKDIV 13'h00b
`define ACR_REG_CHOP 13'h00c
`define ACR_REG_TEST 13'h00d
`define ACR_REG_OFFSET 13'h010
`define ACR_REG_OUTMODE 13'h014

`define ACR_INDEX2_RST 8'h0f
`define ACR_INDEX1_RST 8'h3f
`define ACR_CLKDIV_RST 3'h0
`define ACR_OUTMODE_RST 8'h01

`define ACR_CHOP_BIT 2
`define ACR_PRBS_LONG_RST_BIT 5
`define ACR_PRBS_SHORT_RST_BIT 4
`define ACR_REDUCED_BIT 6
`define ACR_INVERT_BIT 2
`define ACR_TWOS_BIT 0

`define ACR_TM_OFF 4'h0
`define ACR_TM_MIDSCALE 4'h1
`define ACR_TM_POS_FULL_SCALE 4'h2
`define ACR_TM_NEG_FULL_SCALE 4'h3
`define ACR_TM_CHECKER 4'h4
`define ACR_TM_LONG_PRBS 4'h5
`define ACR_TM_SHORT_PRBS 4'h6
`define ACR_TM_WORD_TOGGLE 4'h7
`define ACR_TM_USER 4'h8
`define ACR_TM_BIT_TOGGLE 4'h9
`define ACR_TM_SYNC 4'ha
`define ACR_TM_ONE_BIT_HIGH 4'hb
`define ACR_TM_MIXED_FREQ 4'hc

`define ACR_US_SINGLE 2'h0
`define ACR_US_ALTERNATE 2'h1
`define ACR_US_SINGLE_ONCE 2'h2
`define ACR_US_ALTERNATE_ONCE 2'h3

`define ACR_LONG_PRBS_LEN 23
`define ACR_LONG_PRBS_TAP 18
`define ACR_SHORT_PRBS_LEN 9
`define ACR_SHORT_PRBS_TAP 5

`endif

//--- verilog/acr_spi_slave.v
// three-wire serial port slave: 16-bit instruction then one data byte, pins oversampled on the core clock
`timescale 1ns/1ps
`include "acr_defs.vh"
module acr_spi_slave (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_sclk,
    input wire i_csb,
    input wire i_sdio,
    output wire o_sdio,
    output reg o_sdio_oe,
    output reg [`ACR_ADDR_W-1:0] o_addr,
    output reg [7:0] o_wdata,
    output reg o_wr_stb,
    output reg o_rd_stb,
    input wire [7:0] i_rdata
);
    reg [2:0] sclk_sync_q;
    reg [2:0] csb_sync_q;
    reg [2:0] sdio_sync_q;
    reg sclk_q;
    reg csb_q;
    reg [4:0] cnt_q;
    reg [15:0] sr_q;
    reg read_q;
    reg [7:0] tx_q;
    reg sdo_q;
    wire sclk_rise;
    wire sclk_fall;
    wire csb_act;

    assign sclk_rise = (sclk_sync_q[1] == sclk_sync_q[2]) && sclk_sync_q[2] && !sclk_q;
    assign sclk_fall = (sclk_sync_q[1] == sclk_sync_q[2]) && !sclk_sync_q[2] && sclk_q;
    assign csb_act = !csb_q;
    assign o_sdio = sdo_q;

    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_sync_q <= 3'h0;
            csb_sync_q <= 3'h7;
            sdio_sync_q <= 3'h0;
            sclk_q <= 1'b0;
            csb_q <= 1'b1;
            cnt_q <= 5'h00;
            sr_q <= 16'h0000;
            read_q <= 1'b0;
            tx_q <= 8'h00;
            sdo_q <= 1'b0;
            o_sdio_oe <= 1'b0;
            o_addr <= {`ACR_ADDR_W{1'b0}};
            o_wdata <= 8'h00;
            o_wr_stb <= 1'b0;
            o_rd_stb <= 1'b0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
            csb_sync_q <= {csb_sync_q[1:0], i_csb};
            sdio_sync_q <= {sdio_sync_q[1:0], i_sdio};
            if (sclk_sync_q[1] == sclk_sync_q[2]) begin
                sclk_q <= sclk_sync_q[2];
            end
            if (csb_sync_q[1] == csb_sync_q[2]) begin
                csb_q <= csb_sync_q[2];
            end
            o_wr_stb <= 1'b0;
            o_rd_stb <= 1'b0;
            if (o_rd_stb) begin
                tx_q <= i_rdata;
            end
            if (!csb_act) begin
                cnt_q <= 5'h00;
                read_q <= 1'b0;
                o_sdio_oe <= 1'b0;
            end else if (sclk_rise && cnt_q < 5'd24) begin
                sr_q <= {sr_q[14:0], sdio_sync_q[2]};
                cnt_q <= cnt_q + 5'd1;
                if (cnt_q == 5'd15) begin
                    read_q <= sr_q[14];
                    o_addr <= {sr_q[11:0], sdio_sync_q[2]};
                    o_rd_stb <= sr_q[14];
                end
                if (cnt_q == 5'd23 && !read_q) begin
                    o_wdata <= {sr_q[6:0], sdio_sync_q[2]};
                    o_wr_stb <= 1'b1;
                end
            end else if (sclk_fall && read_q && cnt_q >= 5'd16 && cnt_q < 5'd24) begin
                sdo_q <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                o_sdio_oe <= 1'b1;
            end else if (sclk_fall && cnt_q == 5'd24) begin
                o_sdio_oe <= 1'b0;
            end
        end
    end
endmodule // acr_spi_slave

//--- verilog/acr_prbs.v
// pseudo-random word generator, advances a whole word of steps per sample
`timescale 1ns/1ps
module acr_prbs #(
    parameter LEN = 23,
    parameter TAP = 18,
    parameter W = 14
) (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_clear,
    input wire i_step,
    output wire [W-1:0] o_word
);
    reg [LEN-1:0] state_q;
    reg [LEN-1:0] state_d;
    reg [W-1:0] word_d;
    integer k;

    assign o_word = word_d;

    always @* begin
        state_d = state_q;
        word_d = {W{1'b0}};
        for (k = 0; k < W; k = k + 1) begin
            word_d = {word_d[W-2:0], state_d[LEN-1]};
            state_d = {state_d[LEN-2:0], state_d[LEN-1] ^ state_d[TAP-1]};
        end
    end

    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= {LEN{1'b1}};
        end else if (i_clear) begin
            state_q <= {LEN{1'b1}};
        end else if (i_step) begin
            state_q <= state_d;
        end
    end
endmodule // acr_prbs

//--- verilog/acr_output_config.v
// output configuration register bank with per-channel test pattern, offset and inversion, and global format, datapath
// Contract
// - sample clock divided by field plus one
// - chop mode follows enhancement bit 2
// - four-bit per-channel selector, zero means off
// - midscale, positive and negative full scale words
// - checkerboard, word toggle, bit toggle patterns
// - long and short pseudo-random sequences
// - single sync, one bit high, mixed frequency
// - test data replaces conversion results
// - user sequencing field only in user mode
// - test register per channel, generator resets global
// - per-channel twos complement offset trim
// - bit 6 picks reduced-range signalling, global
// - bit 2 inverts that channel's output
// - bit 0 twos complement, reset value 0x01
// - per-channel writes reach indexed channels only
// - three-wire port, sixteen-bit instruction
`timescale 1ns/1ps
`include "acr_defs.vh"
module acr_output_config #(
    parameter W = 14
) (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_sclk,
    input wire i_csb,
    input wire i_sdio,
    output wire o_sdio,
    output wire o_sdio_oe,
    input wire [8*W-1:0] i_conv_data,
    input wire [15:0] i_user_patt1,
    input wire [15:0] i_user_patt2,
    output reg o_sample_en,
    output wire o_chop_en,
    output wire o_reduced_swing,
    output wire o_clk_out_invert,
    output reg [8*W-1:0] o_chan_data
);
    localparam NCH = 8;
    localparam [7:0] OUTMODE_RST = `ACR_OUTMODE_RST;

    wire [`ACR_ADDR_W-1:0] addr;
    wire [7:0] wdata;
    wire wr_stb;
    wire rd_stb;
    reg [7:0] rdata;

    reg [7:0] index2_q;
    reg [7:0] index1_q;
    reg [2:0] clkdiv_q;
    reg chop_q;
    reg [1:0] prbs_rst_q;
    reg reduced_q;
    reg twos_q;
    reg clk_inv_q;
    reg [NCH*4-1:0] sel_q;
    reg [NCH*2-1:0] useq_q;
    reg [NCH*8-1:0] offs_q;
    reg [NCH-1:0] inv_q;
    reg [NCH*2-1:0] uphase_q;
    reg [NCH*2-1:0] uphase_d;
    reg [8*W-1:0] chan_data_d;
    reg [2:0] div_cnt_q;
    reg toggle_q;
    wire [NCH-1:0] chan_mask;
    wire [W-1:0] long_word;
    wire [W-1:0] short_word;
    wire [2:0] rd_ch;
    integer i;

    function [2:0] first_chan;
        input [NCH-1:0] mask;
        integer j;
        begin
            first_chan = 3'h0;
            for (j = NCH - 1; j >= 0; j = j - 1) begin
                if (mask[j]) begin
                    first_chan = j[2:0];
                end
            end
        end
    endfunction

    function [W-1:0] add_trim;
        input [W-1:0] conv;
        input [7:0] trim;
        reg [W+1:0] sum;
        begin
            sum = {2'b00, conv} + {{(W-6){trim[7]}}, trim};
            if (sum[W+1]) begin
                add_trim = {W{1'b0}};
            end else if (sum[W]) begin
                add_trim = {W{1'b1}};
            end else begin
                add_trim = sum[W-1:0];
            end
        end
    endfunction

    function [W-1:0] fmt;
        input [W-1:0] word;
        input twos;
        begin
            fmt = twos ? {~word[W-1], word[W-2:0]} : word;
        end
    endfunction

    acr_spi_slave u_spi (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_sclk(i_sclk),
        .i_csb(i_csb),
        .i_sdio(i_sdio),
        .o_sdio(o_sdio),
        .o_sdio_oe(o_sdio_oe),
        .o_addr(addr),
        .o_wdata(wdata),
        .o_wr_stb(wr_stb),
        .o_rd_stb(rd_stb),
        .i_rdata(rdata)
    );

    acr_prbs #(
        .LEN(`ACR_LONG_PRBS_LEN),
        .TAP(`ACR_LONG_PRBS_TAP),
        .W(W)
    ) u_long_prbs (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_clear(prbs_rst_q[1]),
        .i_step(o_sample_en),
        .o_word(long_word)
    );

    acr_prbs #(
        .LEN(`ACR_SHORT_PRBS_LEN),
        .TAP(`ACR_SHORT_PRBS_TAP),
        .W(W)
    ) u_short_prbs (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_clear(prbs_rst_q[0]),
        .i_step(o_sample_en),
        .o_word(short_word)
    );

    // channels a..d from index 1, e..h from index 2
    assign chan_mask = {index2_q[3:0], index1_q[3:0]};
    assign rd_ch = first_chan(chan_mask);
    assign o_chop_en = chop_q;
    assign o_reduced_swing = reduced_q;
    assign o_clk_out_invert = clk_inv_q;

    // register read, lowest indexed channel answers for local fields
    always @* begin
        rdata = 8'h00;
        case (addr)
            `ACR_REG_INDEX2: rdata = {4'h0, index2_q[3:0]};
            `ACR_REG_INDEX1: rdata = {2'b00, index1_q[5:0]};
            `ACR_REG_CLKDIV: rdata = {5'h00, clkdiv_q};
            `ACR_REG_CHOP: rdata = {5'h00, chop_q, 2'b00};
            `ACR_REG_TEST: rdata = {useq_q[rd_ch*2 +: 2], prbs_rst_q, sel_q[rd_ch*4 +: 4]};
            `ACR_REG_OFFSET: rdata = offs_q[rd_ch*8 +: 8];
            `ACR_REG_OUTMODE: rdata = {1'b0, reduced_q, 3'h0, inv_q[rd_ch], 1'b0, twos_q};
            default: rdata = 8'h00;
        endcase
    end

    // register writes
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            index2_q <= `ACR_INDEX2_RST;
            index1_q <= `ACR_INDEX1_RST;
            clkdiv_q <= `ACR_CLKDIV_RST;
            chop_q <= 1'b0;
            prbs_rst_q <= 2'b00;
            reduced_q <= OUTMODE_RST[`ACR_REDUCED_BIT];
            twos_q <= OUTMODE_RST[`ACR_TWOS_BIT];
            clk_inv_q <= 1'b0;
            sel_q <= {NCH*4{1'b0}};
            useq_q <= {NCH*2{1'b0}};
            offs_q <= {NCH*8{1'b0}};
            inv_q <= {NCH{1'b0}};
        end else if (wr_stb) begin
            case (addr)
                `ACR_REG_INDEX2: index2_q <= {4'h0, wdata[3:0]};
                `ACR_REG_INDEX1: index1_q <= {2'b00, wdata[5:0]};
                `ACR_REG_CLKDIV: clkdiv_q <= wdata[2:0];
                `ACR_REG_CHOP: chop_q <= wdata[`ACR_CHOP_BIT];
                `ACR_REG_TEST: begin
                    prbs_rst_q <= {wdata[`ACR_PRBS_LONG_RST_BIT], wdata[`ACR_PRBS_SHORT_RST_BIT]};
                    for (i = 0; i < NCH; i = i + 1) begin
                        if (chan_mask[i]) begin
                            sel_q[i*4 +: 4] <= wdata[3:0];
                            useq_q[i*2 +: 2] <= wdata[7:6];
                        end
                    end
                end
                `ACR_REG_OFFSET: begin
                    for (i = 0; i < NCH; i = i + 1) begin
                        if (chan_mask[i]) begin
                            offs_q[i*8 +: 8] <= wdata;
                        end
                    end
                end
                `ACR_REG_OUTMODE: begin
                    reduced_q <= wdata[`ACR_REDUCED_BIT];
                    twos_q <= wdata[`ACR_TWOS_BIT];
                    if (index1_q[5] || index1_q[4]) begin
                        clk_inv_q <= wdata[`ACR_INVERT_BIT];
                    end
                    for (i = 0; i < NCH; i = i + 1) begin
                        if (chan_mask[i]) begin
                            inv_q[i] <= wdata[`ACR_INVERT_BIT];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // sample enable every clkdiv+1 core cycles
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt_q <= 3'h0;
            o_sample_en <= 1'b0;
            toggle_q <= 1'b0;
        end else begin
            if (div_cnt_q >= clkdiv_q) begin
                div_cnt_q <= 3'h0;
                o_sample_en <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + 3'h1;
                o_sample_en <= 1'b0;
            end
            if (o_sample_en) begin
                toggle_q <= ~toggle_q;
            end
        end
    end

    // per-channel pattern selection and next output word
    always @* begin : chan_sel
        reg [W-1:0] word;
        reg [W-1:0] up1;
        reg [W-1:0] up2;
        reg [1:0] ph;
        reg adv;
        integer c;
        word = {W{1'b0}};
        up1 = i_user_patt1[15 -: W];
        up2 = i_user_patt2[15 -: W];
        ph = 2'b00;
        adv = 1'b0;
        c = 0;
        chan_data_d = o_chan_data;
        uphase_d = uphase_q;
        for (c = 0; c < NCH; c = c + 1) begin
            ph = uphase_q[c*2 +: 2];
            word = {W{1'b0}};
            // alternate keeps wrapping, the once modes stop at the last phase
            adv = (ph != 2'b11) || (useq_q[c*2 +: 2] == `ACR_US_ALTERNATE);
            if (wr_stb && addr == `ACR_REG_TEST && chan_mask[c]) begin
                uphase_d[c*2 +: 2] = 2'b00;
            end else if (o_sample_en && sel_q[c*4 +: 4] == `ACR_TM_USER && adv) begin
                uphase_d[c*2 +: 2] = ph + 2'b01;
            end
            if (o_sample_en) begin
                case (sel_q[c*4 +: 4])
                    `ACR_TM_OFF: word = fmt(add_trim(i_conv_data[c*W +: W], offs_q[c*8 +: 8]), twos_q);
                    `ACR_TM_MIDSCALE: word = fmt({1'b1, {(W-1){1'b0}}}, twos_q);
                    `ACR_TM_POS_FULL_SCALE: word = fmt({W{1'b1}}, twos_q);
                    `ACR_TM_NEG_FULL_SCALE: word = fmt({W{1'b0}}, twos_q);
                    `ACR_TM_CHECKER: word = toggle_q ? {(W/2){2'b01}} : {(W/2){2'b10}};
                    `ACR_TM_LONG_PRBS: word = long_word;
                    `ACR_TM_SHORT_PRBS: word = short_word;
                    `ACR_TM_WORD_TOGGLE: word = {W{toggle_q}};
                    `ACR_TM_USER: begin
                        case (useq_q[c*2 +: 2])
                            `ACR_US_SINGLE: word = up1;
                            `ACR_US_ALTERNATE: word = ph[0] ? up2 : up1;
                            `ACR_US_SINGLE_ONCE: word = (ph == 2'b00) ? up1 : {W{1'b0}};
                            `ACR_US_ALTERNATE_ONCE: word = (ph == 2'b00) ? up1 : (ph == 2'b01) ? up2 : {W{1'b0}};
                            default: word = up1;
                        endcase
                    end
                    `ACR_TM_BIT_TOGGLE: word = {(W/2){2'b10}};
                    `ACR_TM_SYNC: word = {{(W/2){1'b0}}, {(W/2){1'b1}}};
                    `ACR_TM_ONE_BIT_HIGH: word = {{(W-1){1'b0}}, 1'b1};
                    `ACR_TM_MIXED_FREQ: word = {{(W/2){2'b10}} ^ {{(W/2){1'b1}}, {(W/2){1'b0}}}};
                    default: word = {W{1'b0}};
                endcase
                chan_data_d[c*W +: W] = inv_q[c] ? ~word : word;
            end
        end
    end

    // output words and user pattern phases
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_chan_data <= {8*W{1'b0}};
            uphase_q <= {NCH*2{1'b0}};
        end else begin
            o_chan_data <= chan_data_d;
            uphase_q <= uphase_d;
        end
    end
endmodule // acr_output_config

//--- verification/acr_output_config_assertions.sv
// concurrent checks on the output configuration bank ports
`timescale 1ns/1ps
module acr_output_config_checker #(
    parameter W = 14
) (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_sclk,
    input wire i_csb,
    input wire i_sdio,
    input wire o_sdio,
    input wire o_sdio_oe,
    input wire [8*W-1:0] i_conv_data,
    input wire [15:0] i_user_patt1,
    input wire [15:0] i_user_patt2,
    input wire o_sample_en,
    input wire o_chop_en,
    input wire o_reduced_swing,
    input wire o_clk_out_invert,
    input wire [8*W-1:0] o_chan_data
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    logic [3:0] gap_q;
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) gap_q <= 4'h0;
        else gap_q <= o_sample_en ? 4'h0 : gap_q + 4'h1;
    end
    sequence csb_idle_s;
        i_csb [*8];
    endsequence
    sample_gap_a: assert property (gap_q < 4'h8) else $error("sample pulse gap too long");
    data_hold_a: assert property (!$past(o_sample_en) |-> $stable(o_chan_data))
        else $error("channel data moved without sample");
    chop_hold_a: assert property (csb_idle_s |=> $stable(o_chop_en)) else $error("chop moved while idle");
    swing_hold_a: assert property (csb_idle_s |=> $stable(o_reduced_swing)) else $error("swing moved");
    invert_hold_a: assert property (csb_idle_s |=> $stable(o_clk_out_invert)) else $error("invert moved");
    oe_idle_a: assert property (csb_idle_s |-> !o_sdio_oe) else $error("data pin driven while idle");
    oe_rise_a: assert property ($rose(o_sdio_oe) |-> !i_csb && $past(i_csb, 8) == 1'b0)
        else $error("data pin driven outside frame");
    oe_release_a: assert property ($rose(i_csb) |-> ##[1:6] !o_sdio_oe) else $error("data pin not released");
endmodule // acr_output_config_checker
bind acr_output_config acr_output_config_checker #(.W(W)) i_acr_output_config_checker (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_csb(i_csb), .i_sdio(i_sdio),
    .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe), .i_conv_data(i_conv_data), .i_user_patt1(i_user_patt1),
    .i_user_patt2(i_user_patt2), .o_sample_en(o_sample_en), .o_chop_en(o_chop_en),
    .o_reduced_swing(o_reduced_swing), .o_clk_out_invert(o_clk_out_invert), .o_chan_data(o_chan_data));

//--- verification/acr_spi_host.sv
// serial port host model issuing three-wire frames
`timescale 1ns/1ps
module acr_spi_host (
    input wire i_core_clk,
    input wire i_sdio,
    output logic o_sclk,
    output logic o_csb,
    output logic o_sdio,
    output logic o_sdio_oe,
    output logic [7:0] o_rd_data,
    output logic o_rd_done
);
    initial begin
        o_sclk = 1'b0;
        o_csb = 1'b1;
        o_sdio = 1'b0;
        o_sdio_oe = 1'b0;
        o_rd_data = 8'h00;
        o_rd_done = 1'b0;
    end
    // instruction msb first then one byte, slow clock idle low
    task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] data);
        logic [23:0] sh;
        sh = {rd, 2'b00, addr, data};
        @(posedge i_core_clk);
        o_csb <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge i_core_clk);
            if (!(rd && i < 8)) begin
                o_sdio <= sh[i];
                o_sdio_oe <= 1'b1;
            end
            repeat (10) @(posedge i_core_clk);
            if (rd && i < 8) o_rd_data[i] <= i_sdio;
            o_sclk <= 1'b1;
            repeat (10) @(posedge i_core_clk);
            o_sclk <= 1'b0;
            if (rd && i == 8) o_sdio_oe <= 1'b0;
        end
        @(posedge i_core_clk);
        o_csb <= 1'b1;
        o_sdio_oe <= 1'b0;
        o_rd_done <= rd;
        @(posedge i_core_clk);
        o_rd_done <= 1'b0;
        repeat (6) @(posedge i_core_clk);
    endtask
endmodule // acr_spi_host

//--- verification/test_acr_output_config.sv
// testbench for the output configuration register bank
`timescale 1ns/1ps
module test_acr_output_config;
    localparam int W = 14;
    typedef struct {int kind; logic [8*W-1:0] val;} acr_note_t;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [8*W-1:0] conv = '0;
    logic [15:0] up1 = 16'h0000;
    logic [15:0] up2 = 16'h0000;
    wire sclk, csb, h_sdio, h_oe, d_sdio, d_oe, rd_done, se, chop, swing, cinv;
    wire [7:0] rd_data;
    wire [8*W-1:0] chan;
    logic last_q = 1'b0;
    logic se_q = 1'b0;
    logic [8*W-1:0] prev_q = '0;
    wire line = h_oe ? h_sdio : (d_oe ? d_sdio : ~last_q);
    acr_note_t q[$];
    int err_count = 0;
    int check_count = 0;
    int gap = 0;
    acr_output_config #(.W(W)) i_acr_output_config (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_sclk(sclk), .i_csb(csb), .i_sdio(line), .o_sdio(d_sdio), .o_sdio_oe(d_oe), .i_conv_data(conv),
        .i_user_patt1(up1), .i_user_patt2(up2), .o_sample_en(se), .o_chop_en(chop),
        .o_reduced_swing(swing), .o_clk_out_invert(cinv), .o_chan_data(chan));
    acr_spi_host i_acr_spi_host (.i_core_clk(i_core_clk), .i_sdio(line), .o_sclk(sclk), .o_csb(csb),
        .o_sdio(h_sdio), .o_sdio_oe(h_oe), .o_rd_data(rd_data), .o_rd_done(rd_done));
    initial begin
        forever #50 i_core_clk = ~i_core_clk;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input string name, input logic [8*W-1:0] exp, input logic [8*W-1:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // released line shows the inverse of its last driven level
    always @(posedge i_core_clk) begin
        if (h_oe || d_oe) last_q <= line;
    end
    always @(posedge i_core_clk) begin
        if (q.size() > 0) begin
            if (q[0].kind == 0 && se_q) cmp("chan_data", q.pop_front().val, chan);
            else if (q[0].kind == 1 && rd_done) cmp("read_byte", q.pop_front().val, rd_data);
            else if (q[0].kind == 2 && se) cmp("sample_gap", q.pop_front().val, gap);
            else if (q[0].kind == 3) cmp("status", q.pop_front().val, {cinv, swing, chop});
            else if (q[0].kind == 4 && se_q) cmp("chan_toggle", q.pop_front().val, chan ^ prev_q);
        end
        if (se_q) prev_q <= chan;
        gap <= se ? 1 : gap + 1;
        se_q <= se;
    end
    task automatic note(input int k, input logic [8*W-1:0] v);
        q.push_back('{k, v});
    endtask
    task automatic settle();
        for (int i = 0; i < 100 && q.size() > 0; i++) @(posedge i_core_clk);
        if (q.size() > 0) begin
            err_count++;
            $display("[FAIL] pending_notes expected %0d seen %0d", 0, q.size());
            q.delete();
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        i_acr_spi_host.xfer(1'b0, a, d);
        repeat (10) @(posedge i_core_clk);
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        note(1, e);
        i_acr_spi_host.xfer(1'b1, a, 8'h00);
        settle();
    endtask
    logic [12:0] regs [6] = '{13'h00b, 13'h00c, 13'h00d, 13'h010, 13'h014, 13'h030};
    logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    logic [7:0] sel_v [13] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h08, 8'hc1, 8'h25, 8'h16,
        8'h88, 8'hc8};
    logic [W-1:0] pat_v [13];
    logic [7:0] tog_v [3] = '{8'h04, 8'h07, 8'h48};
    initial begin
        int unsigned seed;
        int d;
        int s;
        logic [7:0] t;
        logic [8*W-1:0] exp;
        seed = $urandom(32'h9452c24b);
        pat_v = '{14'h0000, 14'h1fff, 14'h2000, 14'h2aaa, 14'h007f, 14'h0001, 14'h152a, 14'h0000, 14'h0000,
            14'h3fff, 14'h3fe0, 14'h0000, 14'h0000};
        repeat (20) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        up1 <= 16'($urandom);
        up2 <= 16'($urandom);
        for (int c = 0; c < 8; c++) conv[c*W+:W] <= W'($urandom);
        repeat (5) @(posedge i_core_clk);
        pat_v[7] = up1[15:2];
        foreach (regs[i]) rd(regs[i], rst_v[i]);
        d = $urandom % 8;
        wr(13'h00b, 8'hf8 | 8'(d));
        repeat (20) @(posedge i_core_clk);
        note(2, d + 1);
        settle();
        rd(13'h00b, 8'(d));
        wr(13'h00b, 8'h00);
        wr(13'h00c, 8'hff);
        note(3, 3'b001);
        rd(13'h00c, 8'h04);
        foreach (sel_v[i]) begin
            wr(13'h00d, sel_v[i]);
            note(0, {8{pat_v[i]}});
            settle();
        end
        foreach (tog_v[i]) begin
            wr(13'h00d, tog_v[i]);
            note(4, {8{i < 2 ? {W{1'b1}} : up1[15:2] ^ up2[15:2]}});
            settle();
        end
        wr(13'h00d, 8'h00);
        wr(13'h004, 8'h00);
        wr(13'h005, 8'h01);
        t = 8'($urandom);
        wr(13'h010, t);
        wr(13'h014, 8'h44);
        s = int'(conv[W-1:0]) + int'($signed(t));
        s = s < 0 ? 0 : (s > 2**W - 1 ? 2**W - 1 : s);
        exp = conv;
        exp[W-1:0] = ~W'(s);
        note(0, exp);
        note(3, 3'b011);
        settle();
        rd(13'h010, t);
        wr(13'h004, 8'h0f);
        wr(13'h005, 8'h3f);
        wr(13'h014, 8'h05);
        note(3, 3'b101);
        settle();
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge i_core_clk);
        err_count++;
        print_verdict();
    end
endmodule // test_acr_output_config
